//--- rtl/rfh_map.svh
// Register offsets, field positions, reset values and timing counts of the refresh block
`ifndef RFH_MAP_SVH
`define RFH_MAP_SVH
`define RFH_OFS_BASE 4'h0
`define RFH_OFS_INTERVAL 4'h2
`define RFH_OFS_CONTROL 4'h4
`define RFH_OFS_ADDRESS 4'h6
`define RFH_EN_BIT 15
`define RFH_CNT_W 9
`define RFH_BASE_W 7
`define RFH_ROW_W 12
`define RFH_BASE_RST 7'h00
`define RFH_INTERVAL_RST 9'h000
`define RFH_ROW_RST 12'h000
`define RFH_REFRESH_CYCLES 3'h4
`endif

//--- rtl/rfh_pkg.sv
// Types shared by the refresh block
package rfh_pkg;
    typedef enum logic [2:0] {
        RFH_IDLE = 3'b000,
        RFH_HELD = 3'b001,
        RFH_WAIT_RELEASE = 3'b010,
        RFH_REFRESH = 3'b011
    } rfh_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } rfh_bus_req_t;

    typedef struct packed {
        logic active;
        logic [19:0] addr;
    } rfh_cycle_t;
endpackage

//--- rtl/rfh_sync.sv
// Two-flop synchroniser for pin inputs
module rfh_sync
    import rfh_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Data
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule

//--- rtl/rfh_interval.sv
// Refresh interval down-counter
`include "rfh_map.svh"
module rfh_interval
    import rfh_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Control
    input wire logic enable_in,
    input wire logic [8:0] reload_in,
    // Status
    output logic [8:0] count_out,
    output logic tick_out
);
    logic [8:0] cnt_ff;
    logic [8:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (!enable_in) begin
            nxt_cnt = 9'h000;
        end else if (cnt_ff <= 9'h001) begin
            nxt_cnt = reload_in;
            nxt_tick = (cnt_ff == 9'h001);
        end else begin
            nxt_cnt = cnt_ff - 9'h001;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_ff <= 9'h000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign count_out = cnt_ff;
    assign tick_out = tick_ff;
endmodule

//--- rtl/rfh_top.sv
// Refresh address generation and bus hold arbitration
//
// The implementer's own choices: the strobed register port and the register offsets.
`include "rfh_map.svh"
module rfh_top
    import rfh_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Bus hold handshake
    input wire logic hold_req_in,
    output logic bus_grant_out,
    // Refresh bus cycle
    output logic refresh_active_out,
    output logic [19:0] refresh_addr_out
);
    rfh_bus_req_t bus_req;
    logic hold_sync;
    logic tick;
    logic [8:0] count;
    logic [3:0] sel;
    logic row_step;

    logic [6:0] base_ff;
    logic [6:0] nxt_base;
    logic [8:0] interval_ff;
    logic [8:0] nxt_interval;
    logic enable_ff;
    logic nxt_enable;
    logic [11:0] row_ff;
    logic [11:0] nxt_row;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;

    rfh_state_t state_ff;
    rfh_state_t nxt_state;
    logic pend_ff;
    logic nxt_pend;
    logic [2:0] cyc_ff;
    logic [2:0] nxt_cyc;
    logic grant_ff;
    logic nxt_grant;
    rfh_cycle_t cycle_ff;
    rfh_cycle_t nxt_cycle;

    assign bus_req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    // Full refresh address with bit 0 forced high
    function automatic logic [19:0] rfh_full_addr(input logic [6:0] b, input logic [11:0] r);
        rfh_full_addr = {b, r, 1'b1};
    endfunction

    // One-hot register select from a bus offset
    function automatic logic [3:0] rfh_decode(input logic [3:0] a);
        if (a == `RFH_OFS_BASE) begin
            rfh_decode = 4'h1;
        end else if (a == `RFH_OFS_INTERVAL) begin
            rfh_decode = 4'h2;
        end else if (a == `RFH_OFS_CONTROL) begin
            rfh_decode = 4'h4;
        end else if (a == `RFH_OFS_ADDRESS) begin
            rfh_decode = 4'h8;
        end else begin
            rfh_decode = 4'h0;
        end
    endfunction

    assign sel = rfh_decode(bus_req.addr);
    // Last cycle of a refresh bus cycle
    assign row_step = (state_ff == RFH_REFRESH) && (cyc_ff <= 3'h1);

    rfh_sync u_hold_sync (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .async_in(hold_req_in),
        .sync_out(hold_sync)
    );

    rfh_interval u_interval (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .enable_in(enable_ff),
        .reload_in(interval_ff),
        .count_out(count),
        .tick_out(tick)
    );

    // Register writes and read data
    always_comb begin
        nxt_base = base_ff;
        nxt_interval = interval_ff;
        nxt_enable = enable_ff;
        nxt_rdata = 16'h0000;
        if (bus_req.wr) begin
            if (sel[0]) begin
                nxt_base = bus_req.wdata[6:0];
            end else if (sel[1]) begin
                nxt_interval = bus_req.wdata[8:0];
            end else if (sel[2]) begin
                nxt_enable = bus_req.wdata[`RFH_EN_BIT];
            end
        end
        if (bus_req.rd) begin
            if (sel[0]) begin
                nxt_rdata = {9'h000, base_ff};
            end else if (sel[1]) begin
                nxt_rdata = {7'h00, interval_ff};
            end else if (sel[2]) begin
                // Mirror reads zero as soon as the enable is off
                nxt_rdata = {enable_ff, 6'h00, enable_ff ? count : 9'h000};
            end else if (sel[3]) begin
                nxt_rdata = {3'h0, row_ff, 1'b1};
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            base_ff <= `RFH_BASE_RST;
            interval_ff <= `RFH_INTERVAL_RST;
            enable_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            base_ff <= nxt_base;
            interval_ff <= nxt_interval;
            enable_ff <= nxt_enable;
            rdata_ff <= nxt_rdata;
        end
    end

    // Hold arbitration and refresh cycle sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_pend = (pend_ff | tick) & enable_ff;
        nxt_cyc = cyc_ff;
        nxt_grant = grant_ff;
        nxt_cycle = '{active: 1'b0, addr: cycle_ff.addr};
        case (state_ff)
            RFH_IDLE: begin
                if (nxt_pend) begin
                    nxt_state = RFH_REFRESH;
                    nxt_pend = 1'b0;
                    nxt_cyc = `RFH_REFRESH_CYCLES;
                    nxt_cycle = '{active: 1'b1, addr: rfh_full_addr(base_ff, row_ff)};
                end else if (hold_sync) begin
                    nxt_state = RFH_HELD;
                    nxt_grant = 1'b1;
                end
            end
            RFH_HELD: begin
                if (nxt_pend) begin
                    nxt_state = RFH_WAIT_RELEASE;
                    nxt_grant = 1'b0;
                end else if (!hold_sync) begin
                    nxt_state = RFH_IDLE;
                    nxt_grant = 1'b0;
                end else begin
                    nxt_grant = 1'b1;
                end
            end
            RFH_WAIT_RELEASE: begin
                nxt_grant = 1'b0;
                if (!hold_sync) begin
                    nxt_state = RFH_REFRESH;
                    nxt_pend = tick;
                    nxt_cyc = `RFH_REFRESH_CYCLES;
                    nxt_cycle = '{active: 1'b1, addr: rfh_full_addr(base_ff, row_ff)};
                end
            end
            RFH_REFRESH: begin
                if (cyc_ff > 3'h1) begin
                    nxt_cyc = cyc_ff - 3'h1;
                    nxt_cycle.active = 1'b1;
                end else begin
                    nxt_cyc = 3'h0;
                    if (hold_sync) begin
                        nxt_state = RFH_HELD;
                        nxt_grant = 1'b1;
                    end else begin
                        nxt_state = RFH_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = RFH_IDLE;
                nxt_grant = 1'b0;
            end
        endcase
        if (!enable_ff) begin
            nxt_pend = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= RFH_IDLE;
            pend_ff <= 1'b0;
            cyc_ff <= 3'h0;
            grant_ff <= 1'b0;
            cycle_ff <= '{active: 1'b0, addr: 20'h0_0000};
        end else begin
            state_ff <= nxt_state;
            pend_ff <= nxt_pend;
            cyc_ff <= nxt_cyc;
            grant_ff <= nxt_grant;
            cycle_ff <= nxt_cycle;
        end
    end

    // Row counter advances once per finished refresh, never into the base
    always_comb begin
        nxt_row = row_ff;
        if (row_step) begin
            nxt_row = row_ff + 12'h001;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            row_ff <= `RFH_ROW_RST;
        end else begin
            row_ff <= nxt_row;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign bus_grant_out = grant_ff;
    assign refresh_active_out = cycle_ff.active;
    assign refresh_addr_out = cycle_ff.addr;
endmodule

//--- verif/rfh_props.sv
// Port checker for the refresh block
module rfh_props
    import rfh_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    // Hold and refresh
    input wire logic hold_req_in,
    input wire logic bus_grant_out,
    input wire logic refresh_active_out,
    input wire logic [19:0] refresh_addr_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_start;
        $rose(refresh_active_out);
    endsequence
    sequence s_cycle;
        refresh_active_out [*4] ##1 !refresh_active_out;
    endsequence
    property p_length; s_start |-> s_cycle; endproperty
    a_length: assert property (p_length) else $error("refresh length wrong");
    property p_excl; !(refresh_active_out && bus_grant_out); endproperty
    a_excl: assert property (p_excl) else $error("refresh while granted");
    property p_reclaim; $fell(bus_grant_out) && hold_req_in |-> ##[1:40] s_start; endproperty
    a_reclaim: assert property (p_reclaim) else $error("grant lost without refresh");
    property p_src; $rose(bus_grant_out) |-> $past(hold_req_in, 3); endproperty
    a_src: assert property (p_src) else $error("grant without hold");
    property p_after; $fell(refresh_active_out) && $past(hold_req_in, 3) |-> ##[0:3] bus_grant_out;
    endproperty
    a_after: assert property (p_after) else $error("no grant after refresh");
    property p_steady; refresh_active_out && $past(refresh_active_out) |-> $stable(refresh_addr_out);
    endproperty
    a_steady: assert property (p_steady) else $error("address moved in cycle");
    property p_lsb; refresh_active_out |-> refresh_addr_out[0]; endproperty
    a_lsb: assert property (p_lsb) else $error("address bit 0 low");
    property p_addr; reg_rd_in && reg_addr_in == 4'h6 |=> reg_rdata_out[0] &&
        reg_rdata_out[15:13] == 3'h0; endproperty
    a_addr: assert property (p_addr) else $error("address read wrong");
    property p_ctrl; reg_rd_in && reg_addr_in == 4'h4 |=> reg_rdata_out[15] ||
        reg_rdata_out[8:0] == 9'h000; endproperty
    a_ctrl: assert property (p_ctrl) else $error("count left when off");
endmodule
bind rfh_top rfh_props u_rfh_props (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .hold_req_in(hold_req_in),
    .bus_grant_out(bus_grant_out), .refresh_active_out(refresh_active_out),
    .refresh_addr_out(refresh_addr_out));

//--- verif/rfh_partner.sv
// Alternate bus master model driving the hold request
module rfh_partner #(
    parameter int LAG = 3
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Handshake
    input wire logic want_in,
    input wire logic bus_grant_in,
    output logic hold_req_out
);
    logic had_ff;
    int cnt_ff;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_req_out <= 1'b0;
            had_ff <= 1'b0;
            cnt_ff <= 0;
        end else if (hold_req_out && had_ff && !bus_grant_in) begin
            if (cnt_ff == LAG) begin
                hold_req_out <= 1'b0;
                had_ff <= 1'b0;
                cnt_ff <= 0;
            end else begin
                cnt_ff <= cnt_ff + 1;
            end
        end else begin
            had_ff <= hold_req_out & (had_ff | bus_grant_in);
            hold_req_out <= want_in;
        end
    end
endmodule

//--- verif/tb_rfh_top.sv
// Testbench for the refresh block
module tb_rfh_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, want = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, d;
    logic hold_req_in, bus_grant_out, refresh_active_out;
    logic [19:0] refresh_addr_out;
    int fails = 0, cmp_count = 0, n, m, k;
    always #5 core_clk_in = ~core_clk_in;
    rfh_top u_rfh_top (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .hold_req_in(hold_req_in), .bus_grant_out(bus_grant_out),
        .refresh_active_out(refresh_active_out), .refresh_addr_out(refresh_addr_out));
    rfh_partner u_rfh_partner (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .want_in(want),
        .bus_grant_in(bus_grant_out), .hold_req_out(hold_req_in));
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task wait_for(input bit g, input logic lvl, input int lim, output int c);
        for (int i = 0; i < lim; i++) begin
            @(posedge core_clk_in);
            #1 c = i + 1;
            if ((g ? bus_grant_out : refresh_active_out) === lvl) return;
        end
        fails++;
        test_done;
    endtask
    task t_reset;
        rd(4'h6);
        chk({4'h0, d}, 20'h0_0001);
        rd(4'h4);
        chk({4'h0, d}, 20'h0_0000);
        wr(4'h6, 16'h1FFE);
        rd(4'h6);
        chk({4'h0, d}, 20'h0_0001);
        rd(4'h8);
        chk({4'h0, d}, 20'h0_0000);
        $display("t_reset done");
    endtask
    task t_refresh;
        wr(4'h0, 16'h0055);
        wr(4'h2, 16'h0014);
        wr(4'h4, 16'h8000);
        rd(4'h4);
        chk({4'h0, d}, 20'h0_8014);
        wait_for(0, 1, 60, n);
        chk(refresh_addr_out, {7'h55, 12'h000, 1'b1});
        wait_for(0, 0, 10, n);
        wait_for(0, 1, 40, m);
        chk(20'(n + m), 20'h0_0014);
        chk(refresh_addr_out, {7'h55, 12'h001, 1'b1});
        wait_for(0, 0, 10, n);
        rd(4'h6);
        chk({4'h0, d}, 20'h0_0005);
        $display("t_refresh done");
    endtask
    task t_wrap;
        wr(4'h2, 16'h0006);
        k = 0;
        do begin
            wait_for(0, 0, 10, n);
            wait_for(0, 1, 20, n);
            k++;
        end while (refresh_addr_out[12:1] !== 12'h000 && k < 5000);
        chk(k[19:0], 20'h0_0FFF);
        chk(refresh_addr_out, {7'h55, 12'h000, 1'b1});
        $display("t_wrap done");
    endtask
    task t_disable;
        wait_for(0, 0, 10, n);
        wr(4'h4, 16'h01FF);
        rd(4'h4);
        chk({4'h0, d}, 20'h0_0000);
        repeat (6) @(posedge core_clk_in);
        repeat (60) begin
            @(posedge core_clk_in);
            #1 chk({19'h0_0000, refresh_active_out}, 20'h0_0000);
        end
        $display("t_disable done");
    endtask
    task t_hold;
        wr(4'h2, 16'h0040);
        wr(4'h4, 16'h8000);
        want <= 1'b1;
        wait_for(1, 1, 20, n);
        wait_for(0, 1, 200, n);
        chk({19'h0_0000, bus_grant_out}, 20'h0_0000);
        wait_for(1, 1, 10, n);
        chk(n[19:0], 20'h0_0004);
        want <= 1'b0;
        wait_for(1, 0, 10, n);
        $display("t_hold done");
    endtask
    initial begin
        repeat (20) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        t_reset;
        t_refresh;
        t_wrap;
        t_disable;
        t_hold;
        test_done;
    end
endmodule
